// *** logic/oos_pkg.sv ***
// constants and types for the power swing / out-of-step sequencer
package oos_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50000000; // system clock rate
	localparam int TICK_US = 1000; // delay resolution, microseconds
	localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US; // cycles per millisecond tick
	localparam int DELAY_W = 16; // delay setting width, 0..65535 ms
	localparam logic [15:0] DELAY_RESET = 16'h0000; // reset value of delay counters
	// ----------------------------------------------------------------
	// trip sequence states
	// ----------------------------------------------------------------
	typedef enum {
		seq_idle,
		seq_step1,
		seq_step2,
		seq_armed,
		seq_armed_late
	} seq_state_t;
endpackage : oos_pkg

// *** logic/ms_timer.sv ***
// millisecond pickup timer: counts ticks while run is high
module ms_timer
	import oos_pkg::*;
#(
	parameter int W = DELAY_W
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic run, // timing condition present
	input wire logic tick, // one-cycle millisecond pulse
	input wire logic [W-1:0] limit, // delay setting in ms
	output logic done // condition held for the full delay
);
	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	logic [W-1:0] count; // elapsed milliseconds
	logic [W-1:0] next_count;

	// count up while run, clear when run drops
	always_comb begin
		next_count = count;
		if (!run) begin
			next_count = '0;
		end else if (tick && count != limit) begin
			next_count = count + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			count <= DELAY_RESET[W-1:0];
		end else begin
			count <= next_count;
		end
	end

	// zero delay completes as soon as run is seen
	assign done = run && (count == limit);
endmodule : ms_timer

// *** logic/power_swing_oos_sequencer.sv ***
// power swing blocking and out-of-step trip sequencer
//
// Behaviour
// R01 - disabled element keeps both outputs low
// R02 - mode selects two-step or three-step sequences
// R03 - two-step uses only outer and inner zones
// R04 - overcurrent supervision gates all zone flags
// R05 - block after outer-not-timing-zone pickup delay one
// R06 - reset delay after leaving outer clears block
// R07 - three-step: middle-not-inner for pickup delay two
// R08 - inner zone for pickup delay three arms
// R09 - delayed mode: delay four then outer exit
// R10 - trip held for the seal-in period
// R11 - early mode trips at arming immediately
// R12 - delayed mode trips on outer zone exit
// R13 - inhibit affects tripping only, not blocking
// R14 - inhibit masks trip, sequence keeps running
// R15 - middle zone ignored in two-step mode
// R16 - two-step skips the pickup delay two stage
// R17 - delays zero to 65535 ms, 1 ms steps
// R18 - reset or disable clears everything to idle
module power_swing_oos_sequencer
	import oos_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES // cycles per ms tick
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic element_enable, // element enable setting
	input wire logic three_step_mode, // 1 = three-step, 0 = two-step
	input wire logic delayed_trip_mode, // 1 = delayed, 0 = early
	input wire logic trip_inhibit_in, // external out-of-step inhibit
	input wire logic outer_zone, // impedance inside outer characteristic
	input wire logic middle_zone, // impedance inside middle characteristic
	input wire logic inner_zone, // impedance inside inner characteristic
	input wire logic overcurrent_ok, // current above overcurrent_supervision_level
	input wire logic [DELAY_W-1:0] pickup_delay1, // ms
	input wire logic [DELAY_W-1:0] reset_delay1, // ms
	input wire logic [DELAY_W-1:0] pickup_delay2, // ms
	input wire logic [DELAY_W-1:0] pickup_delay3, // ms
	input wire logic [DELAY_W-1:0] pickup_delay4, // ms
	input wire logic [DELAY_W-1:0] trip_hold_time, // seal-in, ms
	output logic swing_block, // power swing blocking output
	output logic oos_trip // out-of-step trip output
);
	// ----------------------------------------------------------------
	// millisecond tick divider
	// ----------------------------------------------------------------
	localparam int DIV_W = $clog2(TICK_DIV + 1);
	logic [DIV_W-1:0] div_count; // cycles in current tick
	logic [DIV_W-1:0] next_div_count;
	logic tick; // one-cycle enable every millisecond

	// free-running divider, restarted while disabled
	always_comb begin
		next_div_count = div_count + DIV_W'(1);
		if (!element_enable || div_count == DIV_W'(TICK_DIV - 1)) begin
			next_div_count = '0;
		end
	end

	assign tick = element_enable && (div_count == DIV_W'(TICK_DIV - 1)); // see R17

	always_ff @(posedge clk) begin
		if (!nrst) begin
			div_count <= '0;
		end else begin
			div_count <= next_div_count;
		end
	end

	// ----------------------------------------------------------------
	// supervised zone flags
	// ----------------------------------------------------------------
	logic z_out; // supervised outer zone
	logic z_mid; // supervised middle zone
	logic z_in; // supervised inner zone
	logic z_timing; // zone that ends the first step

	assign z_out = outer_zone && overcurrent_ok; // see R04
	assign z_mid = middle_zone && overcurrent_ok && three_step_mode; // see R03, R15
	assign z_in = inner_zone && overcurrent_ok; // see R04
	assign z_timing = three_step_mode ? z_mid : z_in; // see R02, R05

	// ----------------------------------------------------------------
	// timers
	// ----------------------------------------------------------------
	seq_state_t state; // trip sequence position
	seq_state_t next_state;
	logic latch1; // first-step latch, drives blocking
	logic next_latch1;
	logic [DELAY_W-1:0] hold_count; // seal-in remaining, ms
	logic [DELAY_W-1:0] next_hold_count;
	logic trip_raw; // one-cycle raw trip
	logic next_swing_block;
	logic next_oos_trip;
	logic run1, run2, run3, run4, runr; // timer conditions
	logic done1, done2, done3, done4, doner; // timer completions

	assign run1 = element_enable && z_out && !z_timing; // see R05
	assign run2 = element_enable && state == seq_step1 && z_out && z_mid && !z_in; // see R07
	assign run3 = element_enable && (state == seq_step1 || state == seq_step2) && z_out && z_in; // see R08
	assign run4 = element_enable && state == seq_armed && delayed_trip_mode && z_out && !z_in; // see R09
	assign runr = element_enable && latch1 && !z_out; // see R06

	ms_timer #(.W(DELAY_W)) u_t1 (.clk(clk), .nrst(nrst), .run(run1), .tick(tick),
		.limit(pickup_delay1), .done(done1));
	ms_timer #(.W(DELAY_W)) u_t2 (.clk(clk), .nrst(nrst), .run(run2), .tick(tick),
		.limit(pickup_delay2), .done(done2));
	ms_timer #(.W(DELAY_W)) u_t3 (.clk(clk), .nrst(nrst), .run(run3), .tick(tick),
		.limit(pickup_delay3), .done(done3));
	ms_timer #(.W(DELAY_W)) u_t4 (.clk(clk), .nrst(nrst), .run(run4), .tick(tick),
		.limit(pickup_delay4), .done(done4));
	ms_timer #(.W(DELAY_W)) u_tr (.clk(clk), .nrst(nrst), .run(runr), .tick(tick),
		.limit(reset_delay1), .done(doner));

	// ----------------------------------------------------------------
	// blocking latch
	// ----------------------------------------------------------------
	// set after pickup delay one, cleared by reset delay after outer exit
	always_comb begin
		next_latch1 = latch1;
		if (!element_enable) begin
			next_latch1 = 1'b0; // see R01, R18
		end else if (done1) begin
			next_latch1 = 1'b1; // see R05
		end else if (doner) begin
			next_latch1 = 1'b0; // see R06
		end
		next_swing_block = next_latch1; // see R13
	end

	// ----------------------------------------------------------------
	// out-of-step trip sequence
	// ----------------------------------------------------------------
	// steps hold only while inside outer zone; inhibit does not touch them
	always_comb begin
		next_state = state;
		trip_raw = 1'b0;
		case (state)
			seq_idle: begin
				if (done1) begin
					next_state = seq_step1;
				end
			end
			seq_step1: begin
				if (!z_out) begin
					next_state = seq_idle;
				end else if (done3 && !three_step_mode) begin
					next_state = seq_armed; // see R16
				end else if (done2) begin
					next_state = seq_step2; // see R07
				end
			end
			seq_step2: begin
				if (!z_out) begin
					next_state = seq_idle;
				end else if (done3) begin
					next_state = seq_armed; // see R08
				end
			end
			seq_armed: begin
				if (!delayed_trip_mode) begin
					trip_raw = 1'b1; // see R11
					next_state = seq_idle;
				end else if (!z_out) begin
					next_state = seq_idle;
				end else if (done4) begin
					next_state = seq_armed_late; // see R09
				end
			end
			seq_armed_late: begin
				if (!z_out) begin
					trip_raw = 1'b1; // see R12
					next_state = seq_idle;
				end
			end
			default: begin
				next_state = seq_idle;
			end
		endcase
		if (!element_enable) begin
			next_state = seq_idle; // see R18
			trip_raw = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// seal-in and trip output
	// ----------------------------------------------------------------
	// raw trip loads the hold counter; inhibit masks only the output
	always_comb begin
		next_hold_count = hold_count;
		if (!element_enable) begin
			next_hold_count = '0; // see R18
		end else if (trip_raw) begin
			next_hold_count = trip_hold_time; // see R10
		end else if (tick && hold_count != '0) begin
			next_hold_count = hold_count - DELAY_W'(1);
		end
		next_oos_trip = element_enable && !trip_inhibit_in
			&& (trip_raw || next_hold_count != '0); // see R10, R14
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= seq_idle;
			latch1 <= 1'b0;
			hold_count <= DELAY_RESET;
			swing_block <= 1'b0;
			oos_trip <= 1'b0;
		end else begin
			state <= next_state;
			latch1 <= next_latch1;
			hold_count <= next_hold_count;
			swing_block <= next_swing_block;
			oos_trip <= next_oos_trip;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_DISABLED_QUIET: assert property (@(posedge clk) disable iff (!nrst) // see R01
		!element_enable |=> !swing_block && !oos_trip) else $error("outputs active while disabled");
	AST_INHIBIT_MASK: assert property (@(posedge clk) disable iff (!nrst) // see R14
		trip_inhibit_in |=> !oos_trip) else $error("trip raised under inhibit");
	AST_BLOCK_SET: assert property (@(posedge clk) disable iff (!nrst) // see R05
		element_enable && done1 |=> swing_block) else $error("block not set after delay one");
	AST_BLOCK_CLEAR: assert property (@(posedge clk) disable iff (!nrst) // see R06
		element_enable && doner && !done1 |=> !swing_block) else $error("block not cleared");
	AST_EARLY_TRIP: assert property (@(posedge clk) disable iff (!nrst) // see R11
		element_enable && state == seq_armed && !delayed_trip_mode && !trip_inhibit_in
		|=> oos_trip) else $error("early trip missing");
	AST_LATE_TRIP: assert property (@(posedge clk) disable iff (!nrst) // see R12
		element_enable && state == seq_armed_late && !z_out && !trip_inhibit_in
		|=> oos_trip) else $error("delayed trip missing");
	AST_NO_STEP2_TWO: assert property (@(posedge clk) disable iff (!nrst) // see R16
		!three_step_mode && state == seq_step1 |=> state != seq_step2) else $error("step two in two-step");
	AST_SEAL_IN: assert property (@(posedge clk) disable iff (!nrst) // see R10
		trip_raw && trip_hold_time != '0 && element_enable |=> hold_count == $past(trip_hold_time))
		else $error("seal-in not loaded");
	AST_EXIT_IDLE: assert property (@(posedge clk) disable iff (!nrst) // see R09
		element_enable && state == seq_armed && delayed_trip_mode && !z_out |=> state == seq_idle)
		else $error("early outer exit did not abort");
endmodule : power_swing_oos_sequencer

// *** verif/zone_front_end.sv ***
// impedance front end model: nested zone flags from one locus position
module zone_front_end (
	input wire logic [1:0] pos, // 0 outside, 1 outer, 2 middle, 3 inner
	output logic outer_zone, // inside outer characteristic
	output logic middle_zone, // inside middle characteristic
	output logic inner_zone // inside inner characteristic
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// zone nesting
	// ----------------------------------------------------------------
	// the characteristics are nested, so a hit in a narrow zone implies the wider ones
	always_comb begin
		outer_zone = (pos >= 2'h1);
		middle_zone = (pos >= 2'h2);
		inner_zone = (pos == 2'h3);
	end
endmodule : zone_front_end

// *** verif/power_swing_oos_sequencer_test.sv ***
// self-checking bench for the power swing / out-of-step sequencer
module power_swing_oos_sequencer_test
	import oos_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int TD = 4; // shortened cycles per ms tick
	logic clk = 1'b0, nrst = 1'b0, element_enable = 1'b0, three_step_mode = 1'b0;
	logic delayed_trip_mode = 1'b0, trip_inhibit_in = 1'b0, overcurrent_ok = 1'b1;
	logic [1:0] pos = 2'h0; // locus position fed to the front end model
	logic outer_zone, middle_zone, inner_zone, swing_block, oos_trip;
	logic [DELAY_W-1:0] d1 = 16'h0001, r1 = 16'h0001, d2 = 16'h0002, d3 = 16'h0002, d4 = 16'h0002;
	logic [DELAY_W-1:0] hold = 16'h0003; // seal-in setting
	int n_fail = 0, cmp_count = 0, cyc = 0, n = 0;
	int seed = 32'h6223a711;
	// ----------------------------------------------------------------
	// instances and clock
	// ----------------------------------------------------------------
	zone_front_end i_zone_front_end (.pos(pos), .outer_zone(outer_zone), .middle_zone(middle_zone),
		.inner_zone(inner_zone));
	power_swing_oos_sequencer #(.TICK_DIV(TD)) i_power_swing_oos_sequencer (.clk(clk), .nrst(nrst),
		.element_enable(element_enable), .three_step_mode(three_step_mode),
		.delayed_trip_mode(delayed_trip_mode), .trip_inhibit_in(trip_inhibit_in),
		.outer_zone(outer_zone), .middle_zone(middle_zone), .inner_zone(inner_zone),
		.overcurrent_ok(overcurrent_ok), .pickup_delay1(d1), .reset_delay1(r1), .pickup_delay2(d2),
		.pickup_delay3(d3), .pickup_delay4(d4), .trip_hold_time(hold), .swing_block(swing_block),
		.oos_trip(oos_trip));
	always #10 clk = ~clk; // 50 MHz
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// expectations and helpers
	// ----------------------------------------------------------------
	// earliest and latest cycle count for a delay of d ms, tick granular
	function automatic int lo(input int d);
		return (d > 0) ? (d - 1) * TD : 0;
	endfunction : lo
	function automatic int hi(input int d);
		return (d + 1) * TD + 4;
	endfunction : hi
	// compare and report
	task automatic chk(input logic seen, input logic exp, input string name);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk
	task automatic cycles(input int k);
		repeat (k) @(negedge clk);
	endtask : cycles
	// count cycles until the chosen output reaches lvl, bounded
	task automatic wait_lvl(input logic sel, input logic lvl, output int k);
		k = 0;
		while (((sel ? oos_trip : swing_block) !== lvl) && k < 3000) begin
			@(negedge clk);
			k++;
		end
	endtask : wait_lvl
	// disable, check the clear, then enable in the given modes
	task automatic restart(input logic m3, input logic dl);
		element_enable = 1'b0;
		pos = 2'h0;
		cycles(2);
		chk(swing_block, 1'b0, "block_cleared");
		chk(oos_trip, 1'b0, "trip_cleared");
		three_step_mode = m3;
		delayed_trip_mode = dl;
		element_enable = 1'b1;
	endtask : restart
	task automatic results();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		cycles(16);
		nrst = 1'b1;
		// disabled element stays silent in the outer and inner zones
		pos = 2'h1;
		cycles(40);
		pos = 2'h3;
		cycles(40);
		chk(swing_block, 1'b0, "block_disabled");
		chk(oos_trip, 1'b0, "trip_disabled");
		// random blocking runs, zero delays and inhibit included
		for (int i = 0; i < 8; i++) begin
			restart(i[0], 1'b0);
			d1 = 16'($unsigned($random(seed)) % 5);
			r1 = 16'($unsigned($random(seed)) % 5);
			trip_inhibit_in = 1'($random(seed));
			pos = (i[0] || !i[1]) ? 2'h1 : 2'h2;
			wait_lvl(1'b0, 1'b1, n);
			chk(n >= lo(d1) && n <= hi(d1), 1'b1, "block_pickup");
			pos = 2'h0;
			wait_lvl(1'b0, 1'b0, n);
			chk(n >= lo(r1) && n <= hi(r1), 1'b1, "block_dropout");
		end
		trip_inhibit_in = 1'b0;
		d1 = 16'h0002;
		// timing zone reached too early, and low current, give no block
		restart(1'b1, 1'b0);
		pos = 2'h2;
		cycles(hi(2) + 20);
		chk(swing_block, 1'b0, "block_timing_zone");
		restart(1'b0, 1'b0);
		overcurrent_ok = 1'b0;
		pos = 2'h1;
		cycles(hi(2) + 20);
		chk(swing_block, 1'b0, "block_supervised");
		overcurrent_ok = 1'b1;
		// trip sequence in all four mode combinations
		for (int k = 0; k < 4; k++) begin
			restart(k[0], k[1]);
			pos = 2'h1;
			wait_lvl(1'b0, 1'b1, n);
			if (k[0]) begin
				pos = 2'h3;
				cycles(hi(2) + 8);
				chk(oos_trip, 1'b0, "trip_no_step2");
				pos = 2'h2;
				cycles(hi(2));
			end
			pos = 2'h3;
			if (!k[1]) begin
				wait_lvl(1'b1, 1'b1, n);
				chk(n >= lo(2) && n <= hi(2), 1'b1, "trip_early");
			end else begin
				cycles(hi(2) + 4);
				chk(oos_trip, 1'b0, "trip_wait_exit");
				pos = 2'h1;
				cycles(hi(2));
				chk(oos_trip, 1'b0, "trip_wait_exit");
				pos = 2'h0;
				wait_lvl(1'b1, 1'b1, n);
				chk(n <= 3, 1'b1, "trip_delayed");
			end
			pos = 2'h0;
			wait_lvl(1'b1, 1'b0, n);
			chk(n >= lo(3) && n <= hi(3), 1'b1, "trip_hold");
		end
		// delayed mode: leaving the outer zone before delay four aborts with no trip
		restart(1'b0, 1'b1);
		pos = 2'h1;
		wait_lvl(1'b0, 1'b1, n);
		pos = 2'h3;
		cycles(hi(2) + 4);
		pos = 2'h0;
		cycles(4);
		chk(oos_trip, 1'b0, "trip_aborted");
		// inhibit masks the trip while the sequence runs on
		restart(1'b0, 1'b0);
		hold = 16'h0014;
		trip_inhibit_in = 1'b1;
		pos = 2'h1;
		wait_lvl(1'b0, 1'b1, n);
		chk(swing_block, 1'b1, "block_inhibited");
		pos = 2'h3;
		cycles(hi(2) + 4);
		chk(oos_trip, 1'b0, "trip_masked");
		trip_inhibit_in = 1'b0;
		cycles(3);
		chk(oos_trip, 1'b1, "trip_unmasked");
		// reset in mid-run clears everything
		nrst = 1'b0;
		cycles(2);
		chk(swing_block, 1'b0, "reset_clear_block");
		chk(oos_trip, 1'b0, "reset_clear_trip");
		results();
	end
endmodule : power_swing_oos_sequencer_test
